// ---- rtl/sfe_spi_front_end.sv ----
// Purpose: SPI slave front end of a small serial flash: decode, shift, lane control.
// Assumes: Serial clock half period is at least three system clocks; the array
//    answers mem_rd_data one clock after mem_addr changes.
// Notes: Pull-ups on write-protect and hold live in the pad ring.
// Notes on behaviour
// - Hold low: ignore clock edges and input, float outputs.
// - Hold pauses only the link; running program or erase continues.
// - Hold neither deselects nor resets; command state is kept.
// - Write-protect low locks protected regions; unconnected pin reads high.
// - Only SPI modes 0 and 3; they differ in idle clock level.
// - Sample input on rising edge, launch output on falling edge.
// - Erase at page, 4 KB and 32 KB regions, plus whole array.
// - Dual read turns input lane into output; two bits per clock.
// - Three address bytes accepted; only low fifteen bits decoded.
// - Deselected: outputs floated and input ignored.
`timescale 1ns/1ps
module sfe_spi_front_end
   import sfe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic dual_lane_low_in,
   output logic dual_lane_low_out,
   output logic dual_lane_low_oe,
   output logic dual_lane_high_out,
   output logic dual_lane_high_oe,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic busy,
   output logic [sfe_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rd_data,
   output logic prog_strobe,
   output logic [sfe_pkg::ADDR_W-1:0] prog_addr,
   output logic [7:0] prog_data,
   output logic prog_start,
   output logic erase_start,
   output sfe_pkg::sfe_erase_e erase_kind,
   output logic [sfe_pkg::ADDR_W-1:0] erase_addr,
   output logic wp_lock
);
   import sfe_pkg::*;
   function automatic sfe_op_e decode_op(input logic [7:0] opc);
      case (opc)
         OPC_READ: decode_op = SFE_OP_READ;
         OPC_READ_FAST: decode_op = SFE_OP_FAST;
         OPC_READ_DUAL: decode_op = SFE_OP_DUAL;
         OPC_PROG: decode_op = SFE_OP_PROG;
         OPC_ER_PAGE, OPC_ER_4K, OPC_ER_32K_A, OPC_ER_32K_B,
         OPC_ER_CHIP_A, OPC_ER_CHIP_B, OPC_ER_CHIP_C: decode_op = SFE_OP_ERASE;
         default: decode_op = SFE_OP_NONE;
      endcase
   endfunction
   function automatic sfe_erase_e decode_erase(input logic [7:0] opc);
      case (opc)
         OPC_ER_PAGE: decode_erase = SFE_ER_PAGE;
         OPC_ER_4K: decode_erase = SFE_ER_4K;
         OPC_ER_32K_A, OPC_ER_32K_B: decode_erase = SFE_ER_32K;
         default: decode_erase = SFE_ER_CHIP;
      endcase
   endfunction
   function automatic logic [ADDR_W-1:0] align_erase(input sfe_erase_e k,
                                                     input logic [ADDR_W-1:0] a);
      case (k)
         SFE_ER_PAGE: align_erase = {a[ADDR_W-1:PAGE_W], 8'h00};
         SFE_ER_4K: align_erase = {a[ADDR_W-1:BLK4K_W], 12'h000};
         default: align_erase = ADDR_RST;
      endcase
   endfunction
   sfe_state_e state_reg, state_next;
   sfe_op_e op_reg, op_next;
   sfe_erase_e ekind_reg, ekind_next;
   logic sck_prev_reg, cs_prev_reg;
   logic [1:0] abyte_reg, abyte_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0] page_off_reg, page_off_next;
   logic prog_any_reg, prog_any_next;
   logic [7:0] tx_sh_reg;
   logic [2:0] tx_left_reg;
   logic rx_valid;
   logic [7:0] rx_byte;
   // Hold and deselect both freeze the link; hold never touches state_reg, deselect returns it to SFE_ST_OPCODE
   wire link_active = ~cs_n & hold_n;
   // Edges are found by level change, so mode 0 and mode 3 idle levels both work
   wire sck_rise = link_active & sck & ~sck_prev_reg;
   wire sck_fall = link_active & ~sck & sck_prev_reg;
   wire cs_end = cs_n & ~cs_prev_reg;
   wire is_dual = (op_reg == SFE_OP_DUAL);
   wire in_read = (state_reg == SFE_ST_READ);
   wire tx_load = sck_fall & in_read & (tx_left_reg == 3'h0);
   wire tx_shift = sck_fall & in_read & (tx_left_reg != 3'h0);
   wire [ADDR_W-1:0] addr_shifted = {addr_reg[ADDR_W-9:0], rx_byte};
   wire addr_done = rx_valid & (state_reg == SFE_ST_ADDR) & (abyte_reg == ADDR_LAST_IDX);
   wire data_byte = rx_valid & (state_reg == SFE_ST_PROG);
   // A new operation is not committed while the array is still busy
   wire commit_ok = cs_end & ~busy;
   sfe_rx_shift u_rx (
      .clk(clk),
      .rst(rst),
      .cs_n(cs_n),
      .rise(sck_rise),
      .si(dual_lane_low_in),
      .byte_valid(rx_valid),
      .byte_data(rx_byte)
   );
   always_comb
   begin
      state_next = state_reg;
      op_next = op_reg;
      ekind_next = ekind_reg;
      abyte_next = abyte_reg;
      addr_next = addr_reg;
      page_off_next = page_off_reg;
      prog_any_next = prog_any_reg;
      if (cs_n)
      begin
         state_next = SFE_ST_OPCODE;
         abyte_next = 2'h0;
         prog_any_next = 1'b0;
      end
      else if (rx_valid)
      begin
         case (state_reg)
            SFE_ST_OPCODE:
            begin
               op_next = decode_op(rx_byte);
               ekind_next = decode_erase(rx_byte);
               if (op_next == SFE_OP_NONE)
                  state_next = SFE_ST_IGNORE;
               else if (op_next == SFE_OP_ERASE && ekind_next == SFE_ER_CHIP)
                  state_next = SFE_ST_WAIT;
               else
                  state_next = SFE_ST_ADDR;
            end
            SFE_ST_ADDR:
            begin
               addr_next = addr_shifted;
               abyte_next = abyte_reg + 2'h1;
               if (abyte_reg == ADDR_LAST_IDX)
               begin
                  page_off_next = rx_byte;
                  case (op_reg)
                     SFE_OP_READ: state_next = SFE_ST_READ;
                     SFE_OP_FAST, SFE_OP_DUAL: state_next = SFE_ST_DUMMY;
                     SFE_OP_PROG: state_next = SFE_ST_PROG;
                     default: state_next = SFE_ST_WAIT;
                  endcase
               end
            end
            SFE_ST_DUMMY: state_next = SFE_ST_READ;
            SFE_ST_PROG:
            begin
               page_off_next = page_off_reg + 8'h01;
               prog_any_next = 1'b1;
            end
            default: state_next = state_reg;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= SFE_ST_OPCODE;
         op_reg <= SFE_OP_NONE;
         ekind_reg <= SFE_ER_PAGE;
         abyte_reg <= 2'h0;
         addr_reg <= ADDR_RST;
         page_off_reg <= BYTE_RST;
         prog_any_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         op_reg <= op_next;
         ekind_reg <= ekind_next;
         abyte_reg <= abyte_next;
         addr_reg <= addr_next;
         page_off_reg <= page_off_next;
         prog_any_reg <= prog_any_next;
         // Tracks the clock during hold too, so edges inside the pause are dropped
         sck_prev_reg <= sck;
         cs_prev_reg <= cs_n;
      end
   end
   // Read path: array address advances after each byte load and wraps at the top
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mem_addr <= ADDR_RST;
      else if (addr_done)
         mem_addr <= addr_shifted;
      else if (tx_load)
         mem_addr <= mem_addr + 15'h0001;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_sh_reg <= BYTE_RST;
         tx_left_reg <= 3'h0;
         dual_lane_high_out <= 1'b0;
         dual_lane_low_out <= 1'b0;
      end
      else if (cs_n)
         tx_left_reg <= 3'h0;
      else if (tx_load & is_dual)
      begin
         dual_lane_high_out <= mem_rd_data[7];
         dual_lane_low_out <= mem_rd_data[6];
         tx_sh_reg <= {mem_rd_data[5:0], 2'b00};
         tx_left_reg <= TX_BITS_DUAL;
      end
      else if (tx_load)
      begin
         dual_lane_high_out <= mem_rd_data[7];
         tx_sh_reg <= {mem_rd_data[6:0], 1'b0};
         tx_left_reg <= TX_BITS_SINGLE;
      end
      else if (tx_shift & is_dual)
      begin
         dual_lane_high_out <= tx_sh_reg[7];
         dual_lane_low_out <= tx_sh_reg[6];
         tx_sh_reg <= {tx_sh_reg[5:0], 2'b00};
         tx_left_reg <= tx_left_reg - 3'h1;
      end
      else if (tx_shift)
      begin
         dual_lane_high_out <= tx_sh_reg[7];
         tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         tx_left_reg <= tx_left_reg - 3'h1;
      end
   end
   // Enables drop one clock after hold or deselect; the lanes are still driven meanwhile
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dual_lane_high_oe <= 1'b0;
         dual_lane_low_oe <= 1'b0;
      end
      else
      begin
         dual_lane_high_oe <= link_active & (state_next == SFE_ST_READ);
         dual_lane_low_oe <= link_active & (state_next == SFE_ST_READ) & is_dual;
      end
   end
   // Program bytes stay inside the addressed page; the offset wraps at its end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prog_strobe <= 1'b0;
         prog_addr <= ADDR_RST;
         prog_data <= BYTE_RST;
      end
      else
      begin
         prog_strobe <= data_byte & ~busy;
         if (data_byte)
         begin
            prog_addr <= {addr_reg[ADDR_W-1:PAGE_W], page_off_reg};
            prog_data <= rx_byte;
         end
      end
   end
   // Commit happens at deselect; busy comes from the array timer, not the link
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prog_start <= 1'b0;
         erase_start <= 1'b0;
         erase_kind <= SFE_ER_PAGE;
         erase_addr <= ADDR_RST;
         wp_lock <= 1'b0;
      end
      else
      begin
         prog_start <= commit_ok & (state_reg == SFE_ST_PROG) & prog_any_reg;
         erase_start <= commit_ok & (state_reg == SFE_ST_WAIT);
         if (commit_ok & (state_reg == SFE_ST_WAIT))
         begin
            erase_kind <= ekind_reg;
            erase_addr <= align_erase(ekind_reg, addr_reg);
         end
         wp_lock <= ~wp_n;
      end
   end
endmodule

// ---- rtl/sfe_pkg.sv ----
// Purpose: Shared constants and types of the serial flash front end.
// Assumes: One system clock; SPI pins already synchronous to it.
// Notes: Opcodes cover read, program and erase; other opcodes are ignored.
package sfe_pkg;
   localparam int ADDR_W = 15;
   localparam int PAGE_W = 8;
   localparam int BLK4K_W = 12;
   localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
   localparam logic [2:0] TX_BITS_SINGLE = 3'h7;
   localparam logic [2:0] TX_BITS_DUAL = 3'h3;

   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_READ_FAST = 8'h0b;
   localparam logic [7:0] OPC_READ_DUAL = 8'h3b;
   localparam logic [7:0] OPC_PROG = 8'h02;
   localparam logic [7:0] OPC_ER_PAGE = 8'h81;
   localparam logic [7:0] OPC_ER_4K = 8'h20;
   localparam logic [7:0] OPC_ER_32K_A = 8'h52;
   localparam logic [7:0] OPC_ER_32K_B = 8'hd8;
   localparam logic [7:0] OPC_ER_CHIP_A = 8'h60;
   localparam logic [7:0] OPC_ER_CHIP_B = 8'hc7;
   localparam logic [7:0] OPC_ER_CHIP_C = 8'h62;

   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      SFE_ER_PAGE,
      SFE_ER_4K,
      SFE_ER_32K,
      SFE_ER_CHIP
   } sfe_erase_e;

   typedef enum {
      SFE_OP_NONE,
      SFE_OP_READ,
      SFE_OP_FAST,
      SFE_OP_DUAL,
      SFE_OP_PROG,
      SFE_OP_ERASE
   } sfe_op_e;

   typedef enum {
      SFE_ST_OPCODE,
      SFE_ST_ADDR,
      SFE_ST_DUMMY,
      SFE_ST_READ,
      SFE_ST_PROG,
      SFE_ST_WAIT,
      SFE_ST_IGNORE
   } sfe_state_e;
endpackage

// ---- rtl/sfe_rx_shift.sv ----
// Purpose: Serial input shifter, MSB first, one byte per eight sampled bits.
// Assumes: rise is a one-cycle pulse marking a qualified rising serial clock edge.
// Notes: Cleared only by reset and deselect, so a hold pause keeps the bit position.
`timescale 1ns/1ps
module sfe_rx_shift
   import sfe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic rise,
   input wire logic si,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   import sfe_pkg::*;
   logic [6:0] sh_reg;
   logic [2:0] cnt_reg;
   wire last_bit = (cnt_reg == 3'h7);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sh_reg <= 7'h00;
         cnt_reg <= 3'h0;
      end
      else if (cs_n)
      begin
         sh_reg <= 7'h00;
         cnt_reg <= 3'h0;
      end
      else if (rise)
      begin
         sh_reg <= {sh_reg[5:0], si};
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         byte_valid <= 1'b0;
         byte_data <= BYTE_RST;
      end
      else
      begin
         byte_valid <= rise & last_bit & ~cs_n;
         if (rise & last_bit)
            byte_data <= {sh_reg, si};
      end
   end
endmodule

// ---- sim/sfe_spi_monitor.sv ----
// Purpose: Port checker for the serial flash front end
// Assumes: Serial pins sampled on clk
// Notes: Attached to the top module by bind
`timescale 1ns/1ps
module sfe_spi_monitor
   import sfe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic busy,
   input wire logic dual_lane_high_out,
   input wire logic dual_lane_high_oe,
   input wire logic dual_lane_low_oe,
   input wire logic [sfe_pkg::ADDR_W-1:0] mem_addr,
   input wire logic prog_strobe,
   input wire logic erase_start,
   input wire logic wp_lock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_fall_seen;
      $past(sck, 2) && !$past(sck);
   endsequence
   sequence s_held;
      !hold_n ##1 !hold_n;
   endsequence
   property p_float_desel;
      cs_n |=> !dual_lane_high_oe && !dual_lane_low_oe;
   endproperty
   a_float_desel: assert property (p_float_desel) else $error("lane driven");
   property p_float_hold;
      !hold_n |=> !dual_lane_high_oe && !dual_lane_low_oe;
   endproperty
   a_float_hold: assert property (p_float_hold) else $error("lane driven in hold");
   property p_launch;
      dual_lane_high_oe && $past(dual_lane_high_oe) && $changed(dual_lane_high_out)
         |-> s_fall_seen;
   endproperty
   a_launch: assert property (p_launch) else $error("bit not launched on fall");
   property p_dual;
      dual_lane_low_oe |-> dual_lane_high_oe;
   endproperty
   a_dual: assert property (p_dual) else $error("low lane alone");
   property p_wp;
      $changed(wp_n) |=> wp_lock != $past(wp_lock);
   endproperty
   a_wp: assert property (p_wp) else $error("lock not following");
   // Commit one clock after deselect is first sampled, and only with the array idle
   property p_erase_commit;
      erase_start |-> $past(cs_n) && !$past(cs_n, 2) && !$past(busy);
   endproperty
   a_erase_commit: assert property (p_erase_commit) else $error("bad erase");
   property p_prog_space;
      prog_strobe |=> !prog_strobe [*8];
   endproperty
   a_prog_space: assert property (p_prog_space) else $error("strobe spacing");
   property p_hold_addr;
      s_held |-> $stable(mem_addr);
   endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("moved in hold");
endmodule
bind sfe_spi_front_end sfe_spi_monitor u_mon (.clk, .rst, .cs_n, .sck, .hold_n, .wp_n,
   .busy, .dual_lane_high_out, .dual_lane_high_oe, .dual_lane_low_oe, .mem_addr,
   .prog_strobe, .erase_start, .wp_lock);

// ---- sim/sfe_host_model.sv ----
// Purpose: SPI master model for the serial flash front end
// Assumes: Each serial clock level lasts four system clocks outside a hold pause
// Notes: Released input lane toggles so stale data never looks valid
`timescale 1ns/1ps
module sfe_host_model (
   input wire logic clk,
   input wire logic lane_hi,
   input wire logic lane_lo,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   logic idle_hi;
   initial
   begin
      idle_hi = 1'b0;
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic start(input logic mode3);
      idle_hi = mode3;
      @(posedge clk) sck <= mode3;
      @(posedge clk) cs_n <= 1'b0;
   endtask
   task automatic pause();
      logic keep;
      keep = si;
      @(posedge clk) hold_n <= 1'b0;
      repeat (4) @(posedge clk)
      begin
         sck <= ~sck;
         si <= ~si;
      end
      @(posedge clk)
      begin
         hold_n <= 1'b1;
         si <= keep;
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic dual, input int hold_at,
      output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < (dual ? 4 : 8); i++)
      begin
         @(posedge clk)
         begin
            sck <= 1'b0;
            si <= dual ? ~si : tx[7 - i];
         end
         repeat (3) @(posedge clk);
         if (i == hold_at)
            pause();
         rx = dual ? {rx[5:0], lane_hi, lane_lo} : {rx[6:0], lane_hi};
         @(posedge clk) sck <= 1'b1;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic stop();
      @(posedge clk)
      begin
         cs_n <= 1'b1;
         sck <= idle_hi;
         si <= ~si;
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the serial flash front end
// Assumes: Array modelled as a fixed pattern of the address
// Notes: Array busy is raised only by the refusal test
`timescale 1ns/1ps
module testbench;
   import sfe_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic busy = 1'b0;
   logic [7:0] mem_rd_data = 8'h00;
   logic cs_n, sck, si, hold_n, lo, hi, lo_out, lo_oe, hi_out, hi_oe;
   logic prog_strobe, prog_start, erase_start, wp_lock;
   logic [ADDR_W-1:0] mem_addr, prog_addr, erase_addr;
   logic [7:0] prog_data, rx;
   sfe_erase_e erase_kind;
   logic [22:0] prog_q[$];
   logic [16:0] erase_seen;
   int fails = 0;
   int samples_checked = 0;
   int n_start = 0;
   int n_erase = 0;
   always #20 clk = ~clk;
   assign lo = lo_oe ? lo_out : si;
   assign hi = hi_oe ? hi_out : 1'bz;
   sfe_host_model host (.clk(clk), .lane_hi(hi), .lane_lo(lo), .cs_n(cs_n), .sck(sck),
      .si(si), .hold_n(hold_n));
   sfe_spi_front_end dut (.clk, .rst, .cs_n, .sck, .dual_lane_low_in(lo),
      .dual_lane_low_out(lo_out), .dual_lane_low_oe(lo_oe), .dual_lane_high_out(hi_out),
      .dual_lane_high_oe(hi_oe), .hold_n, .wp_n, .busy, .mem_addr, .mem_rd_data,
      .prog_strobe, .prog_addr, .prog_data, .prog_start, .erase_start, .erase_kind,
      .erase_addr, .wp_lock);
   function automatic logic [7:0] memf(input logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]};
   endfunction
   always @(posedge clk)
   begin
      mem_rd_data <= memf(mem_addr);
      if (prog_strobe === 1'b1) prog_q.push_back({prog_addr, prog_data});
      if (prog_start === 1'b1) n_start++;
      if (erase_start === 1'b1)
      begin
         n_erase++;
         erase_seen = {erase_kind, erase_addr};
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit adr, input int h);
      host.xfer(op, 1'b0, -1, rx);
      for (int i = 2; i >= 0 && adr; i--)
         host.xfer(a[8*i +: 8], 1'b0, (i == 1) ? h : -1, rx);
   endtask
   // Read from a 24-bit address: upper address bits must be dropped and the address wraps at the array end
   task automatic t_read(input logic [7:0] op, input logic [23:0] a, input int h,
      input logic dual, input int n);
      host.start(1'b0);
      cmd(op, a, 1'b1, h);
      if (op != OPC_READ)
         host.xfer(8'h00, 1'b0, -1, rx);
      for (int i = 0; i < n; i++)
      begin
         host.xfer(8'h00, dual, (i == 0) ? h : -1, rx);
         check(rx, memf(a[14:0] + 15'(i)), "read data");
      end
      host.stop();
      $display("read test done");
   endtask
   task automatic t_prog();
      host.start(1'b0);
      cmd(OPC_PROG, 24'h0012fe, 1'b1, -1);
      for (int i = 0; i < 3; i++)
         host.xfer(8'ha1 + 8'(8'h11 * i), 1'b0, -1, rx);
      host.stop();
      check(prog_q.size(), 3, "program count");
      for (int i = 0; i < 3 && i < prog_q.size(); i++)
         check(prog_q[i], {7'h12, 8'hfe + 8'(i), 8'ha1 + 8'(8'h11 * i)}, "page");
      check(n_start, 1, "program commit");
      $display("program test done");
   endtask
   task automatic t_erase();
      int n;
      logic [7:0] ops[7] = '{OPC_ER_PAGE, OPC_ER_4K, OPC_ER_32K_A, OPC_ER_32K_B,
         OPC_ER_CHIP_A, OPC_ER_CHIP_B, OPC_ER_CHIP_C};
      logic [1:0] kinds[7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
      logic [14:0] bases[7] = '{15'h1200, 15'h1000, 15'h0, 15'h0, 15'h0, 15'h0, 15'h0};
      for (int i = 0; i < 7; i++)
      begin
         n = n_erase;
         host.start(i[0]);
         cmd(ops[i], 24'h001234, i < 4, -1);
         host.stop();
         check(n_erase - n, 1, "erase count");
         check(erase_seen, {kinds[i], bases[i]}, "erase kind");
      end
      $display("erase test done");
   endtask
   task automatic t_wp();
      check(wp_lock, 1'b0, "lock idle");
      @(posedge clk) wp_n <= 1'b0;
      repeat (3) @(posedge clk);
      check(wp_lock, 1'b1, "lock on");
      @(posedge clk) wp_n <= 1'b1;
      repeat (3) @(posedge clk);
      check(wp_lock, 1'b0, "lock off");
      $display("protect test done");
   endtask
   // Unknown opcode leaves the frame ignored; a busy array refuses a new commit
   task automatic t_refuse();
      int n;
      n = n_erase;
      host.start(1'b0);
      host.xfer(8'h9f, 1'b0, -1, rx);
      cmd(OPC_ER_CHIP_A, 24'h000000, 1'b0, -1);
      host.stop();
      check(n_erase - n, 0, "unknown opcode acted on");
      @(posedge clk) busy <= 1'b1;
      host.start(1'b1);
      cmd(OPC_ER_CHIP_B, 24'h000000, 1'b0, -1);
      host.stop();
      @(posedge clk) busy <= 1'b0;
      check(n_erase - n, 0, "erase committed while busy");
      $display("refuse test done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_wp();
      t_read(OPC_READ, 24'hff7ffe, -1, 1'b0, 3);
      t_read(OPC_READ_FAST, 24'h000123, 3, 1'b0, 1);
      t_read(OPC_READ_DUAL, 24'h000200, -1, 1'b1, 2);
      t_prog();
      t_erase();
      t_refuse();
      print_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
